/* sac_ctrl.sv */
// Strobe interface, configuration store, conversion sequencer and result RAM of the converter
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Read and write strobes count only while chip select is low.
// - Write rise loads configuration and may start; write fall samples inputs.
// - Busy is low for the whole conversion, high again afterwards.
// - Every input is sampled at once on each start, selected or not.
// - Each selected channel takes 3.6 us and its result goes into RAM.
// - Hard-wired mode: one write starts a full multi-channel conversion.
// - Programmed mode: channels loaded once, later starts convert all stored ones.
// - Each read presents RAM at the pointer, then steps the pointer.
// - Multi-channel conversions clear the read pointer on write fall; in programmed mode after a single write, on write rise.
// - Write with hold-off set loads the pointer without starting; then read.
// - Channel address picks the channel configured or converted, or RAM location.
// - Sleep bit selects power-down; configuration stays writable and kept.
// - Hold-off clear starts on write rise unless sleep is set; hold-off set blocks start only.
// - Polarity bit: 0 unipolar, 1 bipolar, for the addressed channel.
// - Pair bit: 0 single-ended, 1 differential, for the addressed channel.
// - Single bit clear converts all configured channels, read from lowest.
// - Single bit set converts only the addressed channel, one read returns it.
// - Channel choice acts now; polarity and pair settings one conversion later.
// - Open mode pin means programmed mode; strapped pins pick four fixed setups.
// - Data pins driven by the device only during reads.
// - Single-ended channel number follows the address, bit zero least significant.
// - Third address bit exists only on the eight-channel variant.
// - Hard-wired low mode: eight single-ended; high: four differential; data ignored.
// - Latest channel written as differential becomes the pair's positive input.
// - Channels convert lowest first; results are in RAM when busy rises.
// - A write with hold-off and sleep clear starts a conversion however many results were read.
module sac_ctrl
  import sac_pkg::*;
#(
  parameter bit EIGHT_CH = 1'b1
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Host strobes
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  // Shared data pins
  input  wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  // Straps
  input  wire logic              mode_open,
  input  wire logic              mode_level,
  input  wire logic              vss_neg,
  // Converter core
  input  wire logic [DATA_W-1:0] adc_code,
  output logic                   sample_all,
  output logic [CH_W-1:0]        mux_channel,
  output logic                   mux_polarity,
  output logic                   mux_pair,
  output logic                   sleep,
  output logic                   busy_n
);
  localparam int STEP_DLY = CONV_CYC - 1;

  // Every pin crosses three stages; a level is accepted once stages two and three agree
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;
  logic [PIN_W-1:0] pin_s3_r;
  logic [PIN_W-1:0] pin_lvl_r;
  logic             wr_prev_r;
  logic             rd_prev_r;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_r  <= PIN_IDLE;
      pin_s2_r  <= PIN_IDLE;
      pin_s3_r  <= PIN_IDLE;
      pin_lvl_r <= PIN_IDLE;
      wr_prev_r <= 1'b1;
      rd_prev_r <= 1'b1;
    end
    else
    begin
      pin_s1_r  <= {vss_neg, mode_level, mode_open, cs_n, rd_n, wr_n, data_in};
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      pin_lvl_r <= (pin_s2_r & pin_s3_r) | (pin_lvl_r & (pin_s2_r ^ pin_s3_r));
      wr_prev_r <= pin_lvl_r[PIN_WR];
      rd_prev_r <= pin_lvl_r[PIN_RD];
    end
  end

  sac_state_t        state_r;
  logic              cs_lo;
  logic              io_mode;
  logic              wr_fall_ok;
  logic              wr_rise_ok;
  logic              rd_fall_ok;
  logic              rd_rise_ok;
  logic              rd_busy;
  logic [DATA_W-1:0] cfg;
  logic [CH_W-1:0]   cfg_addr;

  assign cs_lo      = ~pin_lvl_r[PIN_CS];
  assign wr_fall_ok = cs_lo && wr_prev_r && !pin_lvl_r[PIN_WR];
  assign wr_rise_ok = cs_lo && !wr_prev_r && pin_lvl_r[PIN_WR];
  assign rd_fall_ok = cs_lo && rd_prev_r && !pin_lvl_r[PIN_RD];
  assign rd_rise_ok = cs_lo && !rd_prev_r && pin_lvl_r[PIN_RD];
  assign rd_busy    = cs_lo && !pin_lvl_r[PIN_RD];
  assign io_mode    = pin_lvl_r[PIN_OPEN];
  assign cfg        = pin_lvl_r[DATA_W-1:0];
  // The four-channel variant has no third address bit
  assign cfg_addr   = cfg[F_ADDR_HI:F_ADDR_LO] & {EIGHT_CH, ADDR_LO_MASK};

  // Per-channel configuration store
  logic [NUM_CH-1:0]   pol_r;
  logic [NUM_CH-1:0]   pair_r;
  logic [NUM_CH-1:0]   sel_r;
  logic [NUM_CH-1:0]   sel_upd;
  logic [NUM_CH/2-1:0] pos_r;
  logic                single_r;

  always_comb
  begin
    sel_upd = sel_r;
    sel_upd[cfg_addr] = 1'b1;
    if (cfg[F_PAIR])
      sel_upd[cfg_addr ^ ADDR_ONE] = 1'b0;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pol_r    <= CH_NONE;
      pair_r   <= CH_NONE;
      sel_r    <= CH_NONE;
      pos_r    <= POS_NONE;
      single_r <= 1'b0;
      sleep    <= 1'b0;
    end
    else if (wr_rise_ok && io_mode)
    begin
      pol_r[cfg_addr]  <= cfg[F_POL];
      pair_r[cfg_addr] <= cfg[F_PAIR];
      if (cfg[F_PAIR])
        pos_r[cfg_addr[CH_W-1:1]] <= cfg_addr[0];
      sel_r    <= sel_upd;
      single_r <= cfg[F_SINGLE];
      sleep    <= cfg[F_SLEEP];
    end
  end

  // Start decision; hard-wired mode ignores the data pins
  logic              start_ok;
  logic [NUM_CH-1:0] start_mask;

  always_comb
  begin
    if (!io_mode)
      start_mask = pin_lvl_r[PIN_LVL] ? HW_PAIR_MASK : HW_SE_MASK;
    else if (cfg[F_SINGLE])
      start_mask = CH_ONE << cfg_addr;
    else
      start_mask = sel_upd;
  end

  // A write during a running conversion still updates the store but cannot restart it
  assign start_ok = wr_rise_ok && (state_r == ST_IDLE)
                    && (!io_mode || (!cfg[F_HOLD] && !cfg[F_SLEEP]));

  function automatic logic [CH_W-1:0] lowest_ch(input logic [NUM_CH-1:0] m);
    logic [CH_W-1:0] c;
    c = ADDR_ZERO;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (m[i])
        c = CH_W'(i);
    return c;
  endfunction

  // Sequencer
  logic [NUM_CH-1:0]   mask_r;
  logic [TICK_W-1:0]   tick_r;
  logic [NUM_CH-1:0]   act_pol_r;
  logic [NUM_CH-1:0]   act_pair_r;
  logic [NUM_CH/2-1:0] act_pos_r;
  logic [CH_W-1:0]     cur_ch;
  logic                push;
  logic                buf_in_ready;
  logic                buf_out_valid;
  logic [BUF_W-1:0]    buf_out_data;

  assign cur_ch = lowest_ch(mask_r);
  assign push   = (state_r == ST_STEP) && (tick_r == CONV_LAST);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r    <= ST_IDLE;
      mask_r     <= CH_NONE;
      tick_r     <= TICK_ZERO;
      act_pol_r  <= CH_NONE;
      act_pair_r <= CH_NONE;
      act_pos_r  <= POS_NONE;
      busy_n     <= 1'b1;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (start_ok)
          begin
            state_r <= ST_STEP;
            mask_r  <= start_mask;
            tick_r  <= TICK_ZERO;
            busy_n  <= 1'b0;
            // Old settings are taken here, so new ones act one conversion later
            act_pol_r  <= io_mode ? pol_r : (pin_lvl_r[PIN_VSS] ? CH_ALL : CH_NONE);
            act_pair_r <= io_mode ? pair_r : (pin_lvl_r[PIN_LVL] ? HW_PAIR_MASK : CH_NONE);
            act_pos_r  <= io_mode ? pos_r : POS_NONE;
          end
        ST_STEP:
          if (!push)
            tick_r <= tick_r + TICK_ONE;
          else if (buf_in_ready)
          begin
            mask_r[cur_ch] <= 1'b0;
            tick_r <= TICK_ZERO;
            if (mask_r == (CH_ONE << cur_ch))
              state_r <= ST_DRAIN;
          end
        ST_DRAIN:
          if (!buf_out_valid)
          begin
            state_r <= ST_IDLE;
            busy_n  <= 1'b1;
          end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Converter core steering
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sample_all   <= 1'b0;
      mux_channel  <= ADDR_ZERO;
      mux_polarity <= 1'b0;
      mux_pair     <= 1'b0;
    end
    else
    begin
      sample_all   <= wr_fall_ok;
      mux_channel  <= act_pair_r[cur_ch] ? {cur_ch[CH_W-1:1], act_pos_r[cur_ch[CH_W-1:1]]} : cur_ch;
      mux_polarity <= act_pol_r[cur_ch];
      mux_pair     <= act_pair_r[cur_ch];
    end
  end

  // A host read owns the RAM port, so results wait in the buffer and the step stalls when it fills
  sac_pair_buf #(
    .W     (BUF_W),
    .DEPTH (2)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   ({cur_ch, adc_code}),
    .out_valid (buf_out_valid),
    .out_ready (!rd_busy),
    .out_data  (buf_out_data)
  );

  logic [DATA_W-1:0] ram_r [NUM_CH];
  logic [CH_W-1:0]   rd_addr_r;

  always_ff @(posedge sys_clk)
    if (buf_out_valid && !rd_busy)
      ram_r[buf_out_data[BUF_W-1:DATA_W]] <= buf_out_data[DATA_W-1:0];

  // Read port and RAM pointer
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_addr_r <= ADDR_ZERO;
      data_out  <= DATA_ZERO;
      data_oe   <= 1'b0;
    end
    else
    begin
      data_oe <= rd_busy;
      if (rd_fall_ok)
        data_out <= ram_r[rd_addr_r];
      if (wr_fall_ok && (!io_mode || !single_r))
        rd_addr_r <= ADDR_ZERO;
      else if (wr_rise_ok && io_mode)
        rd_addr_r <= (cfg[F_HOLD] || cfg[F_SINGLE]) ? cfg_addr : ADDR_ZERO;
      else if (rd_rise_ok)
        rd_addr_r <= rd_addr_r + ADDR_ONE;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_busy_low;
    !busy_n && (state_r == ST_STEP);
  endsequence

  sequence s_read_open;
    data_oe && (data_out == $past(ram_r[rd_addr_r]));
  endsequence

  property p_cs_gate;
    !cs_lo |=> !data_oe;
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("data driven without chip select");

  property p_busy_start;
    start_ok |=> s_busy_low;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not low after start");

  property p_step_time;
    $rose(state_r == ST_STEP) |-> ##STEP_DLY push;
  endproperty
  a_step_time: assert property (p_step_time) else $error("first step not 3.6 us");

  property p_sample;
    wr_fall_ok |=> sample_all;
  endproperty
  a_sample: assert property (p_sample) else $error("inputs not sampled on write fall");

  property p_addr_zero;
    wr_fall_ok && !io_mode |=> rd_addr_r == ADDR_ZERO;
  endproperty
  a_addr_zero: assert property (p_addr_zero) else $error("read pointer not cleared");

  property p_rd_step;
    rd_rise_ok && !wr_fall_ok && !wr_rise_ok |=> rd_addr_r == $past(rd_addr_r) + ADDR_ONE;
  endproperty
  a_rd_step: assert property (p_rd_step) else $error("read pointer did not step");

  property p_rd_data;
    rd_fall_ok |=> s_read_open;
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data not presented");

  property p_hold;
    wr_rise_ok && io_mode && cfg[F_HOLD] && (state_r == ST_IDLE)
      |=> (state_r == ST_IDLE) && (rd_addr_r == $past(cfg_addr));
  endproperty
  a_hold: assert property (p_hold) else $error("held write started or missed address");

  property p_busy_end;
    $rose(busy_n) |-> !buf_out_valid && (mask_r == CH_NONE);
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy rose before results stored");

  property p_hw_start;
    wr_rise_ok && !io_mode && (state_r == ST_IDLE)
      |=> mask_r == ($past(pin_lvl_r[PIN_LVL]) ? HW_PAIR_MASK : HW_SE_MASK);
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("hard-wired start mask wrong");

  property p_latency;
    start_ok && io_mode |=> (act_pol_r == $past(pol_r)) && (act_pair_r == $past(pair_r));
  endproperty
  a_latency: assert property (p_latency) else $error("settings applied without latency");

  property p_single;
    start_ok && io_mode && cfg[F_SINGLE] |=> mask_r == (CH_ONE << $past(cfg_addr));
  endproperty
  a_single: assert property (p_single) else $error("single conversion mask wrong");
endmodule
`default_nettype wire

/* sac_pkg.sv */
// Shared constants and types of the simultaneous-sampling converter control
package sac_pkg;

  // Sizes
  localparam int NUM_CH = 8;
  localparam int CH_W   = 3;
  localparam int DATA_W = 8;
  localparam int BUF_W  = CH_W + DATA_W;

  // Configuration byte fields
  localparam int F_ADDR_LO = 0;
  localparam int F_ADDR_HI = 2;
  localparam int F_SLEEP   = 3;
  localparam int F_HOLD    = 4;
  localparam int F_POL     = 5;
  localparam int F_PAIR    = 6;
  localparam int F_SINGLE  = 7;

  // Synchronised pin vector layout: {vss, mode level, mode open, cs_n, rd_n, wr_n, data}
  localparam int PIN_W    = 14;
  localparam int PIN_WR   = 8;
  localparam int PIN_RD   = 9;
  localparam int PIN_CS   = 10;
  localparam int PIN_OPEN = 11;
  localparam int PIN_LVL  = 12;
  localparam int PIN_VSS  = 13;
  localparam logic [PIN_W-1:0] PIN_IDLE = 14'h0F00;

  // Conversion step timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CONV_TIME_NS  = 3600;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = 7;
  localparam logic [TICK_W-1:0] TICK_ZERO = 7'h00;
  localparam logic [TICK_W-1:0] TICK_ONE  = 7'h01;
  localparam logic [TICK_W-1:0] CONV_LAST = TICK_W'(CONV_CYC - 1);

  // Masks and reset values
  localparam logic [NUM_CH-1:0]   CH_NONE      = 8'h00;
  localparam logic [NUM_CH-1:0]   CH_ALL       = 8'hFF;
  localparam logic [NUM_CH-1:0]   CH_ONE       = 8'h01;
  localparam logic [NUM_CH-1:0]   HW_SE_MASK   = 8'hFF;
  localparam logic [NUM_CH-1:0]   HW_PAIR_MASK = 8'h55;
  localparam logic [NUM_CH/2-1:0] POS_NONE     = 4'h0;
  localparam logic [CH_W-1:0]     ADDR_ZERO    = 3'h0;
  localparam logic [CH_W-1:0]     ADDR_ONE     = 3'h1;
  localparam logic [1:0]          ADDR_LO_MASK = 2'h3;
  localparam logic [DATA_W-1:0]   DATA_ZERO    = 8'h00;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_STEP  = 3'h2,
    ST_DRAIN = 3'h4
  } sac_state_t;

endpackage

/* sac_pair_buf.sv */
// Two-entry valid/ready buffer between the converter steps and the result RAM
`timescale 1ns/1ps
`default_nettype none
module sac_pair_buf
#(
  parameter int W     = 11,
  parameter int DEPTH = 2
)
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Filling side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Draining side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wp_r;
  logic [PW-1:0] rp_r;
  logic [PW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = cnt_r != (PW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk)
    if (push)
      mem_r[wp_r] <= in_data;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1);
      if (pop)
        rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1);
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* sac_host_model.sv */
// Host processor model on the strobe bus of the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_host_model
  import sac_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Bench request
  input  wire logic              req,
  input  wire logic              req_rd,
  input  wire logic              req_nocs,
  input  wire logic [DATA_W-1:0] req_data,
  output logic                   done,
  output logic [DATA_W-1:0]      rd_data,
  // Bus pins
  output logic                   cs_n,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic [DATA_W-1:0]      data_in,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe
);
  logic              host_oe = 1'b0;
  logic [DATA_W-1:0] host_byte = 8'h00;
  logic [DATA_W-1:0] float_pat = 8'hA5;

  // Released pins toggle every cycle so stale data never looks valid
  assign data_in = data_oe ? data_out : (host_oe ? host_byte : float_pat);

  always @(posedge sys_clk) float_pat <= ~float_pat;

  // One process owns cs_n, rd_n and wr_n, so each has a single driver
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    done = 1'b0;
    rd_data = 8'h00;
    forever
    begin
      @(posedge sys_clk);
      if (req === 1'b1 && done === 1'b0)
      begin
        cs_n      <= req_nocs;
        host_oe   <= ~req_rd;
        host_byte <= req_data;
        repeat (6) @(posedge sys_clk);
        if (req_rd) rd_n <= 1'b0;
        else wr_n <= 1'b0;
        repeat (8) @(posedge sys_clk);
        if (req_rd) rd_data <= data_in;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        // Data held past the write rise so the synchronised byte is settled
        repeat (4) @(posedge sys_clk);
        host_oe <= 1'b0;
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        done <= 1'b1;
        while (req === 1'b1) @(posedge sys_clk);
        done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sac_pkg::*;
;
  typedef struct packed {
    logic [DATA_W-1:0] cfg;
    logic [DATA_W-1:0] res;
  } sac_tb_row_t;

  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              mode_open = 1'b1;
  logic              mode_level = 1'b0;
  logic              vss_neg = 1'b0;
  logic [DATA_W-1:0] adc_code = 8'h00;
  logic              req = 1'b0;
  logic              req_rd = 1'b0;
  logic              req_nocs = 1'b0;
  logic [DATA_W-1:0] req_data = 8'h00;
  logic              done, cs_n, rd_n, wr_n, data_oe, sample_all, mux_polarity, mux_pair, sleep, busy_n;
  logic [DATA_W-1:0] rd_data, data_in, data_out;
  logic [CH_W-1:0]   mux_channel;
  int                busy_cyc = 0;
  int                samp_cnt = 0;
  int                err_count = 0;
  int                n_tests = 0;
  sac_tb_row_t       rows [12];

  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  // Core model: the code shows the mux setting that was applied
  always @(posedge sys_clk) adc_code <= {mux_pair, mux_polarity, 3'h5, mux_channel};
  always @(posedge sys_clk) if (busy_n === 1'b0) busy_cyc <= busy_cyc + 1;
  always @(posedge sys_clk) if (sample_all === 1'b1) samp_cnt <= samp_cnt + 1;

  sac_host_model i_host (.sys_clk(sys_clk), .req(req), .req_rd(req_rd), .req_nocs(req_nocs),
    .req_data(req_data), .done(done), .rd_data(rd_data), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  sac_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .mode_open(mode_open),
    .mode_level(mode_level), .vss_neg(vss_neg), .adc_code(adc_code), .sample_all(sample_all),
    .mux_channel(mux_channel), .mux_polarity(mux_polarity), .mux_pair(mux_pair), .sleep(sleep),
    .busy_n(busy_n));

  task automatic print_verdict();
    begin
      $display("checks made %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task automatic bail(input string what);
    begin
      err_count++;
      $display("unexpected wait on %s: expected completion, seen none", what);
      print_verdict();
    end
  endtask

  task automatic chk_v(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    begin
      n_tests++;
      if (got !== exp)
      begin
        err_count++;
        $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    begin
      n_tests++;
      if (got < lo || got > hi)
      begin
        err_count++;
        $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
      end
    end
  endtask

  task automatic host_op(input logic rd, input logic [DATA_W-1:0] b, input logic nocs);
    int k;
    begin
      req_rd   <= rd;
      req_data <= b;
      req_nocs <= nocs;
      req      <= 1'b1;
      k = 0;
      while (done !== 1'b1 && k < 200)
      begin
        @(posedge sys_clk);
        k++;
      end
      if (k == 200) bail("host cycle");
      req <= 1'b0;
      // Done drops only after the model sees req low; a stale done would end the next call at once
      k = 0;
      while (done !== 1'b0 && k < 200)
      begin
        @(posedge sys_clk);
        k++;
      end
      if (k == 200) bail("host release");
    end
  endtask

  task automatic read_chk(input logic [DATA_W-1:0] exp);
    begin
      host_op(1'b1, 8'h00, 1'b0);
      chk_v("read data", exp, rd_data);
    end
  endtask

  // Write, wait for the end of any conversion, then judge its length and the sampling pulse
  task automatic convert(input logic [DATA_W-1:0] b, input int n, input logic nocs);
    int b0;
    int s0;
    int k;
    begin
      b0 = busy_cyc;
      s0 = samp_cnt;
      host_op(1'b0, b, nocs);
      k = 0;
      while (busy_n !== 1'b1 && k < 3000)
      begin
        @(posedge sys_clk);
        k++;
      end
      if (k == 3000) bail("conversion end");
      chk_rng("busy low cycles", n * CONV_CYC, n * CONV_CYC + (n > 0 ? 16 : 0), busy_cyc - b0);
      chk_rng("sample pulses", nocs ? 0 : 1, nocs ? 0 : 1, samp_cnt - s0);
      chk_v("data enable", 8'h00, {7'h00, data_oe});
    end
  endtask

  initial
  begin
    rows = '{'{8'h80, 8'h28}, '{8'h81, 8'h29}, '{8'h82, 8'h2A}, '{8'h83, 8'h2B}, '{8'h84, 8'h2C},
      '{8'h85, 8'h2D}, '{8'h86, 8'h2E}, '{8'h87, 8'h2F}, '{8'hA3, 8'h2B}, '{8'hA3, 8'h6B},
      '{8'h83, 8'h6B}, '{8'h83, 8'h2B}};
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    foreach (rows[i])
    begin
      convert(rows[i].cfg, 1, 1'b0);
      read_chk(rows[i].res);
    end
    host_op(1'b0, 8'hB3, 1'b0);
    convert(8'hA3, 1, 1'b0);
    read_chk(8'h6B);
    host_op(1'b0, 8'h93, 1'b0);
    $display("test single channel rows done");
    convert(8'h00, 8, 1'b0);
    for (int i = 0; i < 8; i++) read_chk(8'h28 | 8'(i));
    $display("test multi channel done");
    convert(8'h15, 0, 1'b0);
    read_chk(8'h2D);
    convert(8'h00, 0, 1'b1);
    $display("test hold-off and chip select done");
    host_op(1'b0, 8'h00, 1'b0);
    repeat (100) @(posedge sys_clk);
    chk_v("busy in run", 8'h00, {7'h00, busy_n});
    rst <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_v("busy after reset", 8'h01, {7'h00, busy_n});
    chk_v("data enable after reset", 8'h00, {7'h00, data_oe});
    repeat (11) @(posedge sys_clk);
    rst <= 1'b0;
    mode_open <= 1'b0;
    repeat (8) @(posedge sys_clk);
    $display("test mid-run reset done");
    convert(8'h18, 8, 1'b0);
    for (int i = 0; i < 8; i++) read_chk(8'h28 | 8'(i));
    mode_level <= 1'b1;
    vss_neg <= 1'b1;
    repeat (8) @(posedge sys_clk);
    convert(8'h18, 4, 1'b0);
    for (int i = 0; i < 8; i++) read_chk((i % 2 == 0) ? (8'hE8 | 8'(i)) : (8'h28 | 8'(i)));
    $display("test hard-wired done");
    mode_open <= 1'b1;
    repeat (8) @(posedge sys_clk);
    convert(8'h08, 0, 1'b0);
    chk_v("sleep flag", 8'h01, {7'h00, sleep});
    $display("test power-down done");
    print_verdict();
  end
endmodule
`default_nettype wire
